// ===== design/pecpc_top.sv
/*
  PHY statistics counters, revision code and PCS configuration high bits,
  with descrambler supervision, carrier sense steering and an interrupt.
  Assumes event inputs are one-cycle pulses from logic on i_sys_clk, and a
  management port on the same clock; the strap is a pin, synchronised.
  The management port has no wait states: a read strobe gives its data
  in the next cycle only, and a write lands at the strobe's edge.
  Unmapped indices read as zero and writes to them are dropped.
  Event pulses must be one cycle wide; a level held high counts on
  every cycle it is seen, which is how the bench reaches the wrap.
  The supervision lengths are parameters so a bench can shorten them.
*/
`timescale 1ns/100ps
`default_nettype none
module pecpc_top
  import pecpc_pkg::*;
#(
  parameter int unsigned LONG_CYC = LONG_TIMER_CYC,
  parameter int unsigned SHORT_CYC = SHORT_TIMER_CYC,
  parameter logic [15:0] DIE_REVISION_CODE = 16'h0001 // Arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_link_lost,
  input wire logic i_carrier_start,
  input wire logic i_jk_seen,
  input wire logic i_rx_error,
  input wire logic i_rx_active,
  input wire logic i_tx_active,
  input wire logic i_collision,
  input wire logic i_full_duplex,
  input wire logic i_idle_symbol,
  input wire logic i_repeater_strap,
  output logic o_nrzi_en,
  output logic o_descr_locked,
  output logic o_descr_restart,
  output logic o_crs,
  output logic o_link_unstable,
  output logic o_irq
);

  typedef enum logic [1:0] {PECPC_SEEK, PECPC_LOCKED} pecpc_lock_t;

  // Register map, by word index:
  // link loss count, read only, wraps at all ones
  // false carrier count, a read clears it, saturates at all ones
  // receive error count, read only, wraps at all ones
  // die revision code, read only, a build parameter
  // PCS configuration, bits 15 to 12 writable, lower bits read zero
  // interrupt status, read only, sticky bits
  // interrupt enable, read and write
  // interrupt clear, write only, a one clears the matching bit
  //
  // Interrupt bit order:
  // bit 0 link loss event
  // bit 1 false carrier event
  // bit 2 faulty packet counted
  // bit 3 descrambler lock lost
  //
  // Configuration bits:
  // bit 15 NRZI coding on, set by reset
  // bit 14 long supervision interval when set
  // bit 13 supervision timer held off when set
  // bit 12 repeater mode when set, node mode when clear
  //
  // Hazards and trade-offs:
  // The false carrier clear and a new event may meet in one cycle;
  // the event is kept as a count of one rather than lost.
  // The strap is sampled once, after the synchroniser has settled,
  // so the strap must be steady a few cycles around reset release.
  // A management write to the configuration before the strap load
  // wins; software intent beats a pin level.
  // The supervision timer is shared by both interval lengths; changing
  // the length mid-interval takes effect against the running count.
  // The idle tally saturates so a long interval cannot wrap it back
  // below the lock threshold.
  // The private carrier check is kept apart from the visible count so
  // that management reads never disturb link stability judgement.
  // Carrier sense is registered, one cycle behind its inputs, which
  // keeps it glitch free at the cost of a cycle of latency.
  // Interrupt status sets beat clears, so an event in the clear cycle
  // is never dropped.
  // The interrupt output is a plain level of status and enable.

  logic [15:0] link_loss_tally_q;
  logic [15:0] bogus_carrier_tally_q;
  logic [15:0] rx_fault_tally_q;
  logic nrzi_en_q;
  logic unscramble_timer_length_q;
  logic unscramble_timer_off_q;
  logic repeater_q;
  logic strap_meta_q;
  logic strap_sync_q;
  logic strap_loaded_q;
  logic in_packet_q;
  logic pkt_err_q;
  logic pkt_coll_q;
  logic [IRQ_WIDTH-1:0] irq_status_q;
  logic [IRQ_WIDTH-1:0] irq_enable_q;
  logic [31:0] sup_timer_q;
  logic [7:0] idle_cnt_q;
  logic [1:0] csc_cnt_q;
  pecpc_lock_t lock_q;
  logic rd_bogus;
  logic pkt_end;
  logic pkt_count;
  logic bogus_event;
  logic sup_expire;
  logic unlock_event;
  logic [31:0] sup_limit;
  logic [IRQ_WIDTH-1:0] irq_events;

  function automatic logic [15:0] wrap_inc(input logic [15:0] v);
    wrap_inc = v + 16'h0001;
  endfunction : wrap_inc

  // Write strobe aimed at one register index
  function automatic logic wr_hit(input logic [4:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction : wr_hit

  // Decode of strobes and derived events
  assign rd_bogus = i_rd && (i_addr == ADDR_BOGUS_CARRIER);
  assign bogus_event = i_carrier_start && !i_jk_seen;
  assign pkt_end = in_packet_q && !i_rx_active;
  assign pkt_count = pkt_end && pkt_err_q && !pkt_coll_q;

  // Link loss count; wraps naturally at all ones
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      link_loss_tally_q <= RST_COUNT;
    end else if (i_link_lost) begin
      link_loss_tally_q <= wrap_inc(link_loss_tally_q);
    end
  end

  // False carrier count; a read clears it, but an event in the read
  // cycle survives as a count of one so nothing is lost
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bogus_carrier_tally_q <= RST_COUNT;
    end else if (rd_bogus) begin
      bogus_carrier_tally_q <= {15'h0000, bogus_event};
    end else if (bogus_event && bogus_carrier_tally_q != COUNT_MAX) begin
      bogus_carrier_tally_q <= wrap_inc(bogus_carrier_tally_q);
    end
  end

  // Packet tracker: remembers errors and collisions within one packet
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      in_packet_q <= 1'b0;
      pkt_err_q <= 1'b0;
      pkt_coll_q <= 1'b0;
    end else begin
      in_packet_q <= i_rx_active;
      if (!in_packet_q) begin
        pkt_err_q <= i_rx_active && i_rx_error;
        pkt_coll_q <= i_rx_active && i_collision;
      end else begin
        pkt_err_q <= pkt_err_q || i_rx_error;
        pkt_coll_q <= pkt_coll_q || i_collision;
      end
    end
  end

  // Receive error count, once per faulty packet without a collision, at its end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_fault_tally_q <= RST_COUNT;
    end else if (pkt_count) begin
      rx_fault_tally_q <= wrap_inc(rx_fault_tally_q);
    end
  end

  // Strap synchroniser; the pin is asynchronous to the core clock
  always_ff @(posedge i_sys_clk) begin
    strap_meta_q <= i_repeater_strap;
    strap_sync_q <= strap_meta_q;
  end

  // Configuration bits; strap value loaded at the first edge after reset
  // release, once the synchroniser holds a clean level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nrzi_en_q <= RST_NRZI_EN;
      unscramble_timer_length_q <= RST_TIMER_LENGTH;
      unscramble_timer_off_q <= RST_TIMER_OFF;
      repeater_q <= 1'b0;
      strap_loaded_q <= 1'b0;
    end else if (wr_hit(ADDR_PCS_CFG)) begin
      nrzi_en_q <= i_wdata[POS_NRZI_EN];
      unscramble_timer_length_q <= i_wdata[POS_TIMER_LENGTH];
      unscramble_timer_off_q <= i_wdata[POS_TIMER_OFF];
      repeater_q <= i_wdata[POS_REPEATER];
      strap_loaded_q <= 1'b1;
    end else if (!strap_loaded_q) begin
      repeater_q <= strap_sync_q;
      strap_loaded_q <= 1'b1;
    end
  end

  // Supervision interval and expiry
  assign sup_limit = unscramble_timer_length_q ? LONG_CYC
                                               : SHORT_CYC;
  assign sup_expire = !unscramble_timer_off_q
                      && (sup_timer_q >= sup_limit - 32'd1);
  // Loss of lock: expiry while locked with too few idles seen
  assign unlock_event = (lock_q == PECPC_LOCKED) && sup_expire
                        && (idle_cnt_q < 8'(MIN_IDLES));

  // Supervision timer restarts each interval; off means never expire
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sup_timer_q <= 32'd0;
      idle_cnt_q <= 8'h00;
    end else if (sup_expire || unscramble_timer_off_q) begin
      sup_timer_q <= 32'd0;
      idle_cnt_q <= 8'h00;
    end else begin
      sup_timer_q <= sup_timer_q + 32'd1;
      if (i_idle_symbol && idle_cnt_q != 8'hFF) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
    end
  end

  // Lock state: enough idles in an interval keep lock
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      lock_q <= PECPC_SEEK;
    end else begin
      case (lock_q)
        PECPC_SEEK: begin
          if (i_idle_symbol && !sup_expire) begin
            lock_q <= PECPC_LOCKED;
          end
        end
        PECPC_LOCKED: begin
          if (sup_expire && idle_cnt_q < 8'(MIN_IDLES)) begin
            lock_q <= PECPC_SEEK;
          end
        end
        default: lock_q <= PECPC_SEEK;
      endcase
    end
  end

  // Restart pulse for the idle search on loss of lock
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_descr_restart <= 1'b0;
    end else begin
      o_descr_restart <= unlock_event;
    end
  end

  // Private carrier stability counter, apart from the visible count
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      csc_cnt_q <= 2'b00;
    end else if (i_carrier_start && i_jk_seen) begin
      csc_cnt_q <= 2'b00;
    end else if (bogus_event && csc_cnt_q != 2'(CSC_LIMIT)) begin
      csc_cnt_q <= csc_cnt_q + 2'b01;
    end
  end

  // Carrier sense steering by mode
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_crs <= 1'b0;
    end else if (repeater_q || i_full_duplex) begin
      o_crs <= i_rx_active;
    end else begin
      o_crs <= i_rx_active || i_tx_active;
    end
  end

  // Sticky interrupt status; a set beats a clear in the same cycle
  assign irq_events = {unlock_event, pkt_count, bogus_event, i_link_lost};
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_status_q <= '0;
    end else if (wr_hit(ADDR_IRQ_CLEAR)) begin
      irq_status_q <= (irq_status_q & ~i_wdata[IRQ_WIDTH-1:0]) | irq_events;
    end else begin
      irq_status_q <= irq_status_q | irq_events;
    end
  end

  // Interrupt enable, one bit per status bit
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_enable_q <= '0;
    end else if (wr_hit(ADDR_IRQ_ENABLE)) begin
      irq_enable_q <= i_wdata[IRQ_WIDTH-1:0];
    end
  end

  // Read data one cycle after the strobe; zero otherwise and unmapped
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= 16'h0000;
    end else begin
      case (i_addr)
        ADDR_LINK_LOSS: o_rdata <= link_loss_tally_q;
        ADDR_BOGUS_CARRIER: o_rdata <= bogus_carrier_tally_q;
        ADDR_RX_FAULT: o_rdata <= rx_fault_tally_q;
        ADDR_DIE_REV: o_rdata <= DIE_REVISION_CODE;
        ADDR_PCS_CFG: o_rdata <= {nrzi_en_q, unscramble_timer_length_q,
                                  unscramble_timer_off_q, repeater_q,
                                  12'h000};
        ADDR_IRQ_STATUS: o_rdata <= {12'h000, irq_status_q};
        ADDR_IRQ_ENABLE: o_rdata <= {12'h000, irq_enable_q};
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // Level outputs
  assign o_nrzi_en = nrzi_en_q;
  assign o_descr_locked = (lock_q == PECPC_LOCKED);
  assign o_link_unstable = (csc_cnt_q == 2'(CSC_LIMIT));
  assign o_irq = |(irq_status_q & irq_enable_q);

endmodule : pecpc_top
`default_nettype wire

// ===== design/pecpc_pkg.sv
/*
  Constants shared by the PHY statistics and PCS configuration block:
  register indices, field positions, reset values and timer lengths.
  Assumes a 125 MHz core clock and word-indexed management addresses.
*/
package pecpc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam logic [4:0] ADDR_LINK_LOSS = 5'h12;
  localparam logic [4:0] ADDR_BOGUS_CARRIER = 5'h13;
  localparam logic [4:0] ADDR_RX_FAULT = 5'h15;
  localparam logic [4:0] ADDR_DIE_REV = 5'h16;
  localparam logic [4:0] ADDR_PCS_CFG = 5'h17;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h18;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h19;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h1A;
  localparam int unsigned POS_NRZI_EN = 15;
  localparam int unsigned POS_TIMER_LENGTH = 14;
  localparam int unsigned POS_TIMER_OFF = 13;
  localparam int unsigned POS_REPEATER = 12;
  localparam logic RST_NRZI_EN = 1'b1;
  localparam logic RST_TIMER_LENGTH = 1'b0;
  localparam logic RST_TIMER_OFF = 1'b0;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam int unsigned IRQ_LINK_LOSS = 0;
  localparam int unsigned IRQ_BOGUS = 1;
  localparam int unsigned IRQ_RX_FAULT = 2;
  localparam int unsigned IRQ_UNLOCK = 3;
  localparam int unsigned IRQ_WIDTH = 4;
  // Supervision intervals in their own units and in cycles (round down)
  localparam int unsigned LONG_TIMER_US = 2000;
  localparam int unsigned SHORT_TIMER_US = 722;
  localparam int unsigned LONG_TIMER_CYC = LONG_TIMER_US * CLK_MHZ;
  localparam int unsigned SHORT_TIMER_CYC = SHORT_TIMER_US * CLK_MHZ;
  localparam int unsigned MIN_IDLES = 8;
  localparam int unsigned CSC_LIMIT = 2;
endpackage : pecpc_pkg

// ===== verification/pecpc_mgmt_model.sv
/*
  Station management model: register writes and reads on the plain port.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module pecpc_mgmt_model (
  input wire logic i_clk,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [15:0] i_rdata
);
  // Idle bus from time zero
  initial begin
    o_addr = 5'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr_reg
  // Data taken after the edge, since it stands for that cycle only
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    v = i_rdata;
  endtask : rd_reg
endmodule : pecpc_mgmt_model
`default_nettype wire

// ===== verification/pecpc_asserts.sv
/*
  Port checker for the statistics and PCS configuration block.
  Assumes it is bound onto pecpc_top, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module pecpc_asserts
  import pecpc_pkg::*;
#(parameter logic [15:0] DIE_REVISION_CODE = 16'h0001) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_carrier_start,
  input wire logic i_rx_active,
  input wire logic i_tx_active,
  input wire logic o_nrzi_en,
  input wire logic o_descr_locked,
  input wire logic o_descr_restart,
  input wire logic o_crs,
  input wire logic o_irq
);
  // All checks on the core clock, quiet in reset
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  property p_crs_idle;
    !i_rx_active && !i_tx_active |=> !o_crs;
  endproperty
  a_crs_idle: assert property (p_crs_idle) else $error("crs idle");
  property p_crs_rx;
    i_rx_active |=> o_crs;
  endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("crs rx");
  // A second read with no event between must see zero
  property p_rd_clear;
    (i_rd && i_addr == ADDR_BOGUS_CARRIER && !i_carrier_start) ##1
      !i_carrier_start ##1 (i_rd && i_addr == ADDR_BOGUS_CARRIER)
      |=> o_rdata == 16'h0000;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("no clear");
  property p_rev;
    i_rd && i_addr == ADDR_DIE_REV |=> o_rdata == DIE_REVISION_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("revision");
  property p_nrzi;
    i_wr && i_addr == ADDR_PCS_CFG |=> o_nrzi_en == $past(i_wdata[15]);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi bit");
  // Reset values seen at the first edge after release
  property p_rst;
    disable iff (1'b0)
    $fell(i_reset) |-> o_nrzi_en && !o_crs && !o_irq && o_rdata == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_restart;
    $fell(o_descr_locked) |-> ##[0:1] o_descr_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_irq_mask;
    i_wr && i_addr == ADDR_IRQ_ENABLE && i_wdata == 16'h0000 |=> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq mask");
  c_irq: cover property (o_irq);
  c_unlock: cover property ($fell(o_descr_locked));
  c_rd_fc: cover property (i_rd && i_addr == ADDR_BOGUS_CARRIER);
endmodule : pecpc_asserts
bind pecpc_top pecpc_asserts
  #(.DIE_REVISION_CODE(DIE_REVISION_CODE)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_carrier_start(i_carrier_start), .i_rx_active(i_rx_active),
  .i_tx_active(i_tx_active), .o_nrzi_en(o_nrzi_en),
  .o_descr_locked(o_descr_locked), .o_descr_restart(o_descr_restart),
  .o_crs(o_crs), .o_irq(o_irq));
`default_nettype wire

// ===== verification/tb_top.sv
/*
  Self-checking bench for pecpc_top with short supervision timers.
  Assumes the repeater strap is pulled high for the whole run.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pecpc_pkg::*;
  localparam logic [15:0] REV = 16'h00A5; // Arbitrary value
  logic i_sys_clk, i_reset, i_wr, i_rd, i_link_lost, i_carrier_start;
  logic i_jk_seen, i_rx_error, i_rx_active, i_tx_active, i_collision;
  logic i_full_duplex, i_idle_symbol, i_repeater_strap, o_nrzi_en;
  logic o_descr_locked, o_descr_restart, o_crs, o_link_unstable, o_irq;
  logic [4:0] i_addr;
  logic [15:0] i_wdata, o_rdata, d;
  int fails = 0;
  int tests_run = 0;
  pecpc_top #(.LONG_CYC(200), .SHORT_CYC(100), .DIE_REVISION_CODE(REV))
    i_pecpc_top (.*);
  pecpc_mgmt_model i_pecpc_mgmt_model (.i_clk(i_sys_clk), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata));
  // 125 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    i_pecpc_mgmt_model.rd_reg(a, d);
    check(d, e);
  endtask : rchk
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    i_pecpc_mgmt_model.wr_reg(a, v);
  endtask : wr
  task automatic do_reset;
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    cyc(5);
    i_reset <= 1'b0;
  endtask : do_reset
  // Event pulses: one carrier start, one idle symbol
  task automatic carrier(input logic jk);
    @(posedge i_sys_clk);
    i_carrier_start <= 1'b1;
    i_jk_seen <= jk;
    @(posedge i_sys_clk);
    i_carrier_start <= 1'b0;
    i_jk_seen <= 1'b0;
  endtask : carrier
  task automatic idle;
    @(posedge i_sys_clk);
    i_idle_symbol <= 1'b1;
    @(posedge i_sys_clk);
    i_idle_symbol <= 1'b0;
    #1;
  endtask : idle
  // Received packet with some error cycles, collision optional
  task automatic pkt(input int errs, input logic col);
    @(posedge i_sys_clk);
    i_rx_active <= 1'b1;
    i_collision <= col;
    repeat (errs) begin
      @(posedge i_sys_clk);
      i_rx_error <= 1'b1;
    end
    @(posedge i_sys_clk);
    i_rx_error <= 1'b0;
    i_rx_active <= 1'b0;
    i_collision <= 1'b0;
    cyc(2);
  endtask : pkt
  task automatic t_reset;
    rchk(ADDR_LINK_LOSS, 16'h0000);
    rchk(ADDR_BOGUS_CARRIER, 16'h0000);
    rchk(ADDR_RX_FAULT, 16'h0000);
    rchk(ADDR_PCS_CFG, 16'h9000);
    wr(ADDR_DIE_REV, 16'h0000);
    rchk(ADDR_DIE_REV, REV);
    rchk(5'h00, 16'h0000);
    $display("reset test done");
  endtask : t_reset
  // Both events held for 65537 cycles: one wraps, one saturates
  task automatic t_count;
    @(posedge i_sys_clk);
    i_link_lost <= 1'b1;
    i_carrier_start <= 1'b1;
    cyc(65537);
    i_link_lost <= 1'b0;
    i_carrier_start <= 1'b0;
    rchk(ADDR_LINK_LOSS, 16'h0001);
    check(16'(o_link_unstable), 16'h0001);
    rchk(ADDR_BOGUS_CARRIER, 16'hFFFF);
    rchk(ADDR_BOGUS_CARRIER, 16'h0000);
    carrier(1'b1);
    rchk(ADDR_BOGUS_CARRIER, 16'h0000);
    check(16'(o_link_unstable), 16'h0000);
    carrier(1'b0);
    rchk(ADDR_BOGUS_CARRIER, 16'h0001);
    pkt(3, 1'b0);
    pkt(1, 1'b1);
    pkt(0, 1'b0);
    pkt(1, 1'b0);
    rchk(ADDR_RX_FAULT, 16'h0002);
    $display("count test done");
  endtask : t_count
  task automatic t_pcr;
    wr(ADDR_PCS_CFG, 16'hFFFF);
    rchk(ADDR_PCS_CFG, 16'hF000);
    wr(ADDR_PCS_CFG, 16'h0000);
    @(posedge i_sys_clk);
    i_tx_active <= 1'b1;
    cyc(2);
    #1;
    check(16'(o_nrzi_en), 16'h0000);
    check(16'(o_crs), 16'h0001);
    @(posedge i_sys_clk);
    i_full_duplex <= 1'b1;
    cyc(2);
    #1;
    check(16'(o_crs), 16'h0000);
    @(posedge i_sys_clk);
    i_full_duplex <= 1'b0;
    wr(ADDR_PCS_CFG, 16'h1000);
    cyc(2);
    #1;
    check(16'(o_crs), 16'h0000);
    @(posedge i_sys_clk);
    i_tx_active <= 1'b0;
    i_rx_active <= 1'b1;
    cyc(2);
    #1;
    check(16'(o_crs), 16'h0001);
    @(posedge i_sys_clk);
    i_rx_active <= 1'b0;
    $display("config test done");
  endtask : t_pcr
  task automatic t_descr;
    int n;
    int k = 0;
    wr(ADDR_PCS_CFG, 16'h8000);
    idle();
    check(16'(o_descr_locked), 16'h0001);
    for (n = 0; n < 300 && o_descr_locked; n++) begin
      cyc(1);
      #1;
    end
    check(16'(n < 102), 16'h0001);
    for (n = 0; n < 60; n++) begin
      idle();
      cyc(3);
      #1;
      if (n > 25 && o_descr_locked !== 1'b1) k++;
    end
    check(16'(k), 16'h0000);
    wr(ADDR_PCS_CFG, 16'hA000);
    cyc(400);
    #1;
    check(16'(o_descr_locked), 16'h0001);
    wr(ADDR_PCS_CFG, 16'hC000);
    cyc(150);
    #1;
    check(16'(o_descr_locked), 16'h0001);
    cyc(100);
    #1;
    check(16'(o_descr_locked), 16'h0000);
    $display("descrambler test done");
  endtask : t_descr
  // Masked event, then enable, then clear
  task automatic t_irq;
    wr(ADDR_IRQ_ENABLE, 16'h0000);
    wr(ADDR_IRQ_CLEAR, 16'h000F);
    @(posedge i_sys_clk);
    i_link_lost <= 1'b1;
    @(posedge i_sys_clk);
    i_link_lost <= 1'b0;
    i_pecpc_mgmt_model.rd_reg(ADDR_IRQ_STATUS, d);
    check(d & 16'h0001, 16'h0001);
    check(16'(o_irq), 16'h0000);
    wr(ADDR_IRQ_ENABLE, 16'h0001);
    #1;
    check(16'(o_irq), 16'h0001);
    wr(ADDR_IRQ_CLEAR, 16'h0001);
    #1;
    check(16'(o_irq), 16'h0000);
    $display("interrupt test done");
  endtask : t_irq
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Main sequence; strap high so reset picks repeater mode
  initial begin
    {i_reset, i_repeater_strap} = 2'b11;
    {i_link_lost, i_carrier_start, i_jk_seen, i_rx_error} = 4'h0;
    {i_rx_active, i_tx_active, i_collision, i_full_duplex} = 4'h0;
    i_idle_symbol = 1'b0;
    do_reset();
    t_reset();
    t_count();
    t_pcr();
    t_descr();
    t_irq();
    do_reset();
    t_reset();
    summarize();
  end
  // Run should need about 67k cycles; give up at 80k
  initial begin
    #640000;
    fails++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
